// ==== hw/fsp_pkg.sv ====
package fsp_pkg;

    // ----------------------------------------
    // flash geometry, in instruction words
    // ----------------------------------------
    localparam int unsigned FSP_ADDR_W = 24;
    localparam int unsigned FSP_PAGE_SHIFT = 9;
    localparam int unsigned FSP_PAGE_IW = 512;
    localparam int unsigned FSP_VT_IW = 256;
    localparam int unsigned FSP_FLASH_IW_DEF = 32768;
    localparam int unsigned FSP_CFG_IW_DEF = 64;
    localparam int unsigned FSP_BLIM_W = 13;
    localparam logic [FSP_BLIM_W-1:0] FSP_MIN_PAGES = 13'h0001;
    localparam logic [FSP_BLIM_W-1:0] FSP_MIN_PAGES_ALT = 13'h0002;

    // ----------------------------------------
    // security configuration word fields
    // ----------------------------------------
    localparam int unsigned FSP_SEC_W = 16;
    localparam int unsigned FSP_SEC_BOOT_WP = 0;
    localparam int unsigned FSP_SEC_BOOT_CP = 1;
    localparam int unsigned FSP_SEC_GEN_WP = 4;
    localparam int unsigned FSP_SEC_GEN_CP = 5;
    localparam int unsigned FSP_SEC_CFG_WP = 8;
    localparam int unsigned FSP_SEC_CFG_CP = 9;
    localparam int unsigned FSP_SEC_ALT_EN = 14;
    localparam logic [1:0] FSP_CP_NONE = 2'h3;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    localparam int unsigned FSP_RADDR_W = 4;
    localparam int unsigned FSP_DATA_W = 32;
    localparam logic [FSP_RADDR_W-1:0] FSP_REG_CTRL = 4'h0;
    localparam logic [FSP_RADDR_W-1:0] FSP_REG_STATUS = 4'h4;
    localparam logic [FSP_RADDR_W-1:0] FSP_REG_DENY_CNT = 4'h8;
    localparam int unsigned FSP_CTRL_RELOAD = 0;
    localparam int unsigned FSP_CTRL_LOCK = 1;
    localparam logic [15:0] FSP_CNT_RST = 16'h0000;

    // ----------------------------------------
    // regions and carriers
    // ----------------------------------------
    typedef enum logic [1:0] {
        FSP_RGN_BOOT,
        FSP_RGN_GEN,
        FSP_RGN_CFG,
        FSP_RGN_NONE
    } fsp_region_e;

    typedef struct packed {
        logic boot_en;
        logic alt_en;
        logic boot_wp;
        logic [1:0] boot_cp;
        logic gen_wp;
        logic [1:0] gen_cp;
        logic cfg_wp;
        logic [1:0] cfg_cp;
        logic [FSP_BLIM_W-1:0] boot_pages;
    } fsp_cfg_s;

    typedef struct packed {
        logic valid;
        logic erase;
        logic from_boot;
        logic [FSP_ADDR_W-1:0] addr;
    } fsp_req_s;

    typedef struct packed {
        logic valid;
        logic grant;
        fsp_region_e region;
    } fsp_ans_s;

endpackage : fsp_pkg

// ==== hw/fsp_code_protect.sv ====
`timescale 1ns/1ps
module fsp_code_protect import fsp_pkg::*; #(
    parameter int unsigned FLASH_IW = FSP_FLASH_IW_DEF,
    parameter int unsigned CFG_IW = FSP_CFG_IW_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [FSP_SEC_W-1:0] security_config_word_i,
    input wire logic [FSP_BLIM_W-1:0] boot_page_count_field_i,
    input wire fsp_req_s req_i,
    output fsp_ans_s ans_o,
    output logic ready_o,
    input wire logic [FSP_RADDR_W-1:0] reg_addr_i,
    input wire logic [FSP_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [FSP_DATA_W-1:0] reg_rdata_o
);

    localparam logic [FSP_ADDR_W-1:0] FLASH_END = FSP_ADDR_W'(FLASH_IW);
    localparam logic [FSP_ADDR_W-1:0] CFG_BASE = FSP_ADDR_W'(FLASH_IW - CFG_IW);
    localparam logic [FSP_ADDR_W-1:0] VT_END = FSP_ADDR_W'(FSP_VT_IW);

    fsp_cfg_s cfg_reg;
    fsp_cfg_s cfg_next;
    logic load_pend_reg;
    logic lock_reg;
    logic [15:0] deny_cnt_reg;
    fsp_ans_s ans_next;

    // ----------------------------------------
    // configuration capture
    // ----------------------------------------
    always_comb begin
        cfg_next.alt_en = security_config_word_i[FSP_SEC_ALT_EN];
        cfg_next.boot_wp = security_config_word_i[FSP_SEC_BOOT_WP];
        cfg_next.boot_cp = security_config_word_i[FSP_SEC_BOOT_CP +: 2];
        cfg_next.gen_wp = security_config_word_i[FSP_SEC_GEN_WP];
        cfg_next.gen_cp = security_config_word_i[FSP_SEC_GEN_CP +: 2];
        cfg_next.cfg_wp = security_config_word_i[FSP_SEC_CFG_WP];
        cfg_next.cfg_cp = security_config_word_i[FSP_SEC_CFG_CP +: 2];
        // zero pages means no boot segment at all
        cfg_next.boot_en = (boot_page_count_field_i != '0);
        cfg_next.boot_pages = boot_page_count_field_i;
        if (cfg_next.boot_en && (cfg_next.boot_pages < FSP_MIN_PAGES)) begin
            cfg_next.boot_pages = FSP_MIN_PAGES;
        end
        if (cfg_next.boot_en && cfg_next.alt_en && (cfg_next.boot_pages < FSP_MIN_PAGES_ALT)) begin
            cfg_next.boot_pages = FSP_MIN_PAGES_ALT;
        end
    end

    // settings sampled on the first edge after reset, never under reset itself
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_reg <= '0;
        end else if (load_pend_reg) begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            load_pend_reg <= 1'b1;
        end else if (reg_wr_i && (reg_addr_i == FSP_REG_CTRL) && reg_wdata_i[FSP_CTRL_RELOAD] && !lock_reg) begin
            load_pend_reg <= 1'b1;
        end else begin
            load_pend_reg <= 1'b0;
        end
    end

    // lock is sticky until reset: blocks reloads of the settings
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lock_reg <= 1'b0;
        end else if (reg_wr_i && (reg_addr_i == FSP_REG_CTRL) && reg_wdata_i[FSP_CTRL_LOCK]) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !load_pend_reg;
        end
    end

    // ----------------------------------------
    // region decode and decision
    // ----------------------------------------
    logic [FSP_BLIM_W-1:0] req_page;
    logic in_boot;
    logic in_cfg;
    logic in_vt;
    logic last_boot_page;
    logic alt_page;

    always_comb begin
        req_page = FSP_BLIM_W'(req_i.addr >> FSP_PAGE_SHIFT);
        in_cfg = (req_i.addr >= CFG_BASE) && (req_i.addr < FLASH_END);
        in_boot = cfg_reg.boot_en && (req_page < cfg_reg.boot_pages) && !in_cfg;
        in_vt = (req_i.addr < VT_END);
        last_boot_page = in_boot && (req_page == (cfg_reg.boot_pages - FSP_MIN_PAGES));
        alt_page = last_boot_page && cfg_reg.alt_en;

        ans_next.valid = req_i.valid && ready_o;
        ans_next.grant = 1'b0;
        ans_next.region = FSP_RGN_NONE;
        if (req_i.addr >= FLASH_END) begin
            ans_next.region = FSP_RGN_NONE;
        end else if (in_cfg) begin
            ans_next.region = FSP_RGN_CFG;
            ans_next.grant = !cfg_reg.cfg_wp && (req_i.from_boot || cfg_reg.cfg_cp == FSP_CP_NONE);
        end else if (in_vt) begin
            ans_next.region = cfg_reg.boot_en ? FSP_RGN_BOOT : FSP_RGN_GEN;
            ans_next.grant = !cfg_reg.boot_wp && !cfg_reg.gen_wp;
        end else if (in_boot) begin
            ans_next.region = FSP_RGN_BOOT;
            if (last_boot_page && req_i.from_boot) begin
                ans_next.grant = 1'b1;
            end else if (alt_page) begin
                ans_next.grant = (cfg_reg.boot_cp == FSP_CP_NONE);
            end else begin
                ans_next.grant = !cfg_reg.boot_wp && (req_i.from_boot || cfg_reg.boot_cp == FSP_CP_NONE);
            end
        end else begin
            ans_next.region = FSP_RGN_GEN;
            ans_next.grant = !cfg_reg.gen_wp;
        end
        if (!ans_next.valid) begin
            ans_next.grant = 1'b0;
        end
    end

    // answer one cycle after the request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ans_o <= '{valid: 1'b0, grant: 1'b0, region: FSP_RGN_NONE};
        end else begin
            ans_o <= ans_next;
        end
    end

    // ----------------------------------------
    // refusal counter and register port
    // ----------------------------------------
    // saturates so software never sees a wrap
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            deny_cnt_reg <= FSP_CNT_RST;
        end else if (ans_next.valid && !ans_next.grant && (deny_cnt_reg != 16'hffff)) begin
            deny_cnt_reg <= deny_cnt_reg + 16'h0001;
        end else if (reg_wr_i && (reg_addr_i == FSP_REG_DENY_CNT)) begin
            deny_cnt_reg <= FSP_CNT_RST;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                FSP_REG_CTRL: reg_rdata_o <= {30'h0000_0000, lock_reg, 1'b0};
                FSP_REG_STATUS: reg_rdata_o <= {7'h00, cfg_reg.cfg_cp, cfg_reg.cfg_wp, cfg_reg.gen_cp,
                    cfg_reg.gen_wp, cfg_reg.boot_cp, cfg_reg.boot_wp, cfg_reg.alt_en, cfg_reg.boot_en,
                    ready_o, cfg_reg.boot_pages[12:0]};
                FSP_REG_DENY_CNT: reg_rdata_o <= {16'h0000, deny_cnt_reg};
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule : fsp_code_protect

// ==== test/fsp_props.sv ====
`timescale 1ns/1ps
module fsp_props import fsp_pkg::*; #(
    parameter int unsigned FLASH_IW = FSP_FLASH_IW_DEF,
    parameter int unsigned CFG_IW = FSP_CFG_IW_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [FSP_SEC_W-1:0] security_config_word_i,
    input wire logic [FSP_BLIM_W-1:0] boot_page_count_field_i,
    input wire fsp_req_s req_i,
    input wire fsp_ans_s ans_o,
    input wire logic ready_o,
    input wire logic [FSP_RADDR_W-1:0] reg_addr_i,
    input wire logic [FSP_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [FSP_DATA_W-1:0] reg_rdata_o
);
    // ----------------------------------------
    // checks, settings held steady between resets
    // ----------------------------------------
    logic tk;
    logic lo;
    logic [14:0] pg;
    logic [14:0] lim;
    assign tk = req_i.valid && ready_o;
    assign lo = req_i.addr < FLASH_IW - CFG_IW;
    assign pg = req_i.addr[23:9];
    assign lim = {2'b00, boot_page_count_field_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_answer_on_time: assert property (tk |=> ans_o.valid)
        else $error("answer missing");
    a_no_spurious_answer: assert property (!tk |=> !ans_o.valid)
        else $error("answer without request");
    a_out_of_flash: assert property (tk && req_i.addr >= FLASH_IW |=> !ans_o.grant && ans_o.region == FSP_RGN_NONE)
        else $error("outside flash granted");
    a_cfg_region: assert property (tk && !lo && req_i.addr < FLASH_IW |=> ans_o.region == FSP_RGN_CFG)
        else $error("config region wrong");
    a_vector_lock: assert property (tk && req_i.addr < 256 && (security_config_word_i[FSP_SEC_BOOT_WP]
        || security_config_word_i[FSP_SEC_GEN_WP]) |=> !ans_o.grant)
        else $error("vector table not locked");
    a_gen_wp_deny: assert property (tk && lo && pg >= lim + 2 && security_config_word_i[FSP_SEC_GEN_WP]
        |=> !ans_o.grant)
        else $error("protected general granted");
    a_gen_region: assert property (tk && lo && pg >= lim + 2 |=> ans_o.region == FSP_RGN_GEN)
        else $error("general region wrong");
    a_boot_region: assert property (tk && lo && lim >= 2 && pg < lim |=> ans_o.region == FSP_RGN_BOOT)
        else $error("boot region wrong");
    a_last_page_boot: assert property (tk && lo && req_i.from_boot && lim >= 2 && pg == lim - 1
        |=> ans_o.grant)
        else $error("last boot page refused");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data outside slot");
endmodule : fsp_props

bind fsp_code_protect fsp_props #(.FLASH_IW(FLASH_IW), .CFG_IW(CFG_IW)) u_props (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .security_config_word_i(security_config_word_i),
    .boot_page_count_field_i(boot_page_count_field_i), .req_i(req_i), .ans_o(ans_o), .ready_o(ready_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));

// ==== test/fsp_req_model.sv ====
`timescale 1ns/1ps
module fsp_req_model import fsp_pkg::*; (
    input wire logic clk_i,
    input wire fsp_ans_s ans_i,
    output fsp_req_s req_o
);
    initial req_o = '0;
    // one request per call; idle fields inverted so stale values never match
    task automatic send(input logic er, input logic fb, input logic [FSP_ADDR_W-1:0] a, output fsp_ans_s got);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, erase: er, from_boot: fb, addr: a};
        @(posedge clk_i);
        req_o <= '{valid: 1'b0, erase: ~er, from_boot: ~fb, addr: ~a};
        #1;
        got = ans_i;
    endtask : send
endmodule : fsp_req_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench import fsp_pkg::*;;
    localparam logic [23:0] W = 24'h00_0200;
    localparam logic [23:0] TOP = 24'h00_8000;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] sec = 16'h0666;
    logic [12:0] pages = 13'h0004;
    fsp_req_s req;
    fsp_ans_s ans;
    logic ready, wr = 1'b0, rd = 1'b0;
    logic [3:0] ra = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdata;
    int n_mismatch = 0;
    int checks_done = 0;
    initial forever #10 clk_i = ~clk_i;
    fsp_code_protect #(.FLASH_IW(32768), .CFG_IW(64)) i_fsp_code_protect (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .security_config_word_i(sec), .boot_page_count_field_i(pages), .req_i(req), .ans_o(ans),
        .ready_o(ready), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
    fsp_req_model u_req (.clk_i(clk_i), .ans_i(ans), .req_o(req));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cfg(input logic [15:0] s, input logic [12:0] p);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        sec <= s;
        pages <= p;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("ready", 1, ready);
    endtask : cfg
    // program and erase must be judged alike
    task automatic go(input logic fb, input logic [23:0] a, input logic g, input fsp_region_e r);
        fsp_ans_s got;
        for (int e = 0; e < 2; e++) begin
            u_req.send(e[0], fb, a, got);
            chk("valid", 1, got.valid);
            chk("grant", g, got.grant);
            chk("region", r, got.region);
        end
    endtask : go
    task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        ra <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) chk("rdata", d, rdata);
    endtask : rw
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_map();
        cfg(16'h4666, 13'h0004);
        rw(0, FSP_REG_STATUS, 32'h01b6_e004);
        go(0, 24'h00_0000, 1, FSP_RGN_BOOT);
        go(0, 4 * W, 1, FSP_RGN_GEN);
        go(0, TOP - 1, 1, FSP_RGN_CFG);
        go(1, TOP, 0, FSP_RGN_NONE);
    endtask : t_map
    task automatic t_boot_wp();
        cfg(16'h4667, 13'h0004);
        go(1, 24'h00_0010, 0, FSP_RGN_BOOT);
        go(0, W, 0, FSP_RGN_BOOT);
        go(0, 3 * W, 1, FSP_RGN_BOOT);
        go(1, 3 * W, 1, FSP_RGN_BOOT);
        go(0, 8 * W, 1, FSP_RGN_GEN);
    endtask : t_boot_wp
    task automatic t_no_boot();
        cfg(16'h0666, 13'h0000);
        go(0, 24'h00_0010, 1, FSP_RGN_GEN);
        cfg(16'h0676, 13'h0000);
        go(0, 24'h00_0010, 0, FSP_RGN_GEN);
        go(1, 8 * W, 0, FSP_RGN_GEN);
    endtask : t_no_boot
    task automatic t_min_size();
        cfg(16'h0666, 13'h0001);
        go(0, 24'h00_00ff, 1, FSP_RGN_BOOT);
        go(0, W, 1, FSP_RGN_GEN);
        cfg(16'h4666, 13'h0001);
        go(0, W, 1, FSP_RGN_BOOT);
        go(0, 2 * W, 1, FSP_RGN_GEN);
    endtask : t_min_size
    task automatic t_privilege();
        cfg(16'h0060, 13'h0004);
        go(0, W, 0, FSP_RGN_BOOT);
        go(1, W, 1, FSP_RGN_BOOT);
        go(0, TOP - 1, 0, FSP_RGN_CFG);
        go(1, TOP - 1, 1, FSP_RGN_CFG);
        rw(0, FSP_REG_DENY_CNT, 32'h0000_0004);
        rw(1, FSP_REG_DENY_CNT, 32'h0000_0000);
        rw(0, FSP_REG_DENY_CNT, 32'h0000_0000);
        rw(0, 4'hc, 32'h0000_0000);
        rw(1, FSP_REG_CTRL, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        chk("ready", 0, ready);
        repeat (2) @(posedge clk_i);
        #1;
        chk("ready", 1, ready);
        rw(1, FSP_REG_CTRL, 32'h0000_0002);
        rw(0, FSP_REG_CTRL, 32'h0000_0002);
        rw(1, FSP_REG_CTRL, 32'h0000_0001);
        @(posedge clk_i);
        #1;
        chk("ready", 1, ready);
    endtask : t_privilege
    initial begin
        t_map();
        t_boot_wp();
        t_no_boot();
        t_min_size();
        t_privilege();
        report_and_stop();
    end
    initial begin
        #200us;
        n_mismatch++;
        report_and_stop();
    end
endmodule : testbench
